// >>> hw/scu_pkg.sv
// constants and types shared by the serial control block
// assumes a wishbone slave with byte registers on word addresses
`default_nettype none
package scu_pkg;
  // ******************************
  // register byte addresses
  // ******************************
  localparam logic [7:0] SCU_CTRL1 = 8'h00;
  localparam logic [7:0] SCU_CTRL2 = 8'h04;
  localparam logic [7:0] SCU_STAT  = 8'h08;
  localparam logic [7:0] SCU_DATA  = 8'h0C;
  localparam logic [7:0] SCU_BRKC  = 8'h10;
  // ******************************
  // field positions
  // ******************************
  localparam int C1_LOOP = 7;
  localparam int C1_EN   = 6;
  localparam int C1_INV  = 5;
  localparam int C1_LONG = 4;
  localparam int C1_WAKE = 3;
  localparam int C1_IDLE_COUNT_START_SELECT = 2;
  localparam int C1_PEN  = 1;
  localparam int C1_PTY  = 0;
  localparam int C2_TIE  = 7;
  localparam int C2_TX_COMPLETE_IRQ_ENABLE = 6;
  localparam int C2_RIE  = 5;
  localparam int C2_IDLE_LINE_IRQ_ENABLE = 4;
  localparam int C2_TE   = 3;
  localparam int C2_RE   = 2;
  localparam int C2_RWU  = 1;
  localparam int C2_SBK  = 0;
  // ******************************
  // reset values and counts
  // ******************************
  localparam logic [7:0]  SCU_CTRL_RST = 8'h00;
  localparam logic        SCU_BREAK_FLAG_CLEAR_ENABLE_RST = 1'b0;
  localparam logic [15:0] SCU_BIT_CYC  = 16'h0010;
  localparam logic [3:0]  SCU_LEN_SHORT = 4'hA;
  localparam logic [3:0]  SCU_LEN_LONG  = 4'hB;
  // ******************************
  // transmitter states
  // ******************************
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_BRK  = 2'b10
  } scu_tx_t;
endpackage
`default_nettype wire

// >>> hw/scu_sci_ctrl.sv
// serial control block: control registers, transmitter, receiver
// assumes a classic wishbone master and a break module on mclk_i
//
// What this block does
// - enabled flag clear in debug break sticks
// - protected debug break leaves status flags unchanged
// - first clear step survives break, second clears
// - enabled module forces pin directions
// - loop mode feeds transmitter into receiver
// - module enable gates logic, sets empty flags
// - inversion flips every transmitted level
// - long bit selects nine bit characters
// - wake bit selects address mark wakeup
// - idle count starts after stop or start
// - parity occupies most significant character bit
// - parity type selects odd or even
// - separate enables for transmitter interrupt sources
// - separate enables for receiver interrupt sources
// - transmitter enable sends preamble of ones
// - disabling transmitter finishes character, requeues idle
// - receiver enable gates reception, keeps flags
// - standby masks receiver interrupts until wakeup
// - send break emits breaks then one
// - early break replaces the pending preamble
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module scu_sci_ctrl
  import scu_pkg::*;
#(
  parameter logic [15:0] BIT_CYC = scu_pkg::SCU_BIT_CYC
)(
  input  wire logic        mclk_i,               // 10 MHz bus clock
  input  wire logic        nrst_i,               // sync reset, low
  input  wire logic        ce_i,                 // clock enable
  input  wire logic        wb_cyc_i,             // bus cycle
  input  wire logic        wb_stb_i,             // bus strobe
  input  wire logic        wb_we_i,              // write
  input  wire logic [7:0]  wb_adr_i,             // byte address
  input  wire logic [3:0]  wb_sel_i,             // byte lanes
  input  wire logic [31:0] wb_dat_i,             // write data
  output logic      [31:0] wb_dat_o,             // read data
  output logic             wb_ack_o,             // acknowledge
  input  wire logic        dbg_break_i,          // debug break state
  input  wire logic        port_dir_bit_one_i,   // port dir, rx pin
  input  wire logic        port_dir_bit_two_i,   // port dir, tx pin
  input  wire logic        port_tx_dat_i,        // port latch, tx pin
  input  wire logic        port_rx_dat_i,        // port latch, rx pin
  output logic             shared_transmit_pin_o,    // tx pin level
  output logic             shared_transmit_pin_oe_o, // tx pin drive
  input  wire logic        shared_receive_pin_i,     // rx pin level
  output logic             shared_receive_pin_o,     // rx pin level out
  output logic             shared_receive_pin_oe_o,  // rx pin drive
  output logic             tx_irq_o,             // transmitter request
  output logic             rx_irq_o              // receiver request
);
  import scu_pkg::*;

  // ******************************
  // state
  // ******************************
  typedef struct packed {
    logic [7:0]  c1;
    logic [7:0]  c2;
    logic        break_flag_clear_enable;
    logic        ack;
    logic [8:0]  dat;
    logic [8:0]  txbuf;
    logic        tx_empty;
    logic        arm_te;
    logic        te_q;
    logic        pre_pend;
    logic        brk_tail;
    scu_tx_t     tx_st;
    logic [9:0]  tx_sh;
    logic [3:0]  tx_n;
    logic [15:0] tx_cnt;
    logic        txd;
    logic [2:0]  rx_s;
    logic        rx_lvl;
    logic        rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_n;
    logic [9:0]  rx_sh;
    logic [8:0]  rx_data;
    logic        rx_full;
    logic        idle;
    logic        perr;
    logic        arm_rf;
    logic        arm_id;
    logic        arm_pe;
    logic [3:0]  ocnt;
    logic        idl_done;
    logic        seen;
  } scu_st_t;

  scu_st_t s;
  scu_st_t next_s;

  logic        en;
  logic        m_long;
  logic        prot;
  logic        acc;
  logic        tx_tick;
  logic        rx_tick;
  logic        tx_free;
  logic        tc;
  logic        rxin;
  logic        te;
  logic        send_break;
  logic        receiver_standby;
  logic [3:0]  len;
  logic [8:0]  tx_dat;
  logic [10:0] tx_frame;
  logic [8:0]  rx_word;
  logic        rx_msb;
  logic        rx_perr;
  logic [15:0] half_cyc;

  // ******************************
  // decoded controls
  // ******************************
  // module enable gates everything except the receiver request and the rx pin level out
  assign en       = s.c1[C1_EN];
  assign m_long   = s.c1[C1_LONG];
  assign len      = m_long ? SCU_LEN_LONG : SCU_LEN_SHORT;
  assign te       = s.c2[C2_TE];
  assign send_break      = s.c2[C2_SBK];
  assign receiver_standby      = s.c2[C2_RWU];
  assign prot     = dbg_break_i & ~s.break_flag_clear_enable;
  assign acc      = wb_cyc_i & wb_stb_i & ~s.ack;
  assign tx_tick  = (s.tx_cnt == 16'h0000);
  assign rx_tick  = (s.rx_cnt == 16'h0000);
  assign half_cyc = (BIT_CYC >> 1) - 16'h0001;
  // loop takes the raw transmitter level
  assign rxin     = s.c1[C1_LOOP] ? s.txd : s.rx_lvl;
  assign tx_free  = (s.tx_st == TX_IDLE) | (tx_tick & (s.tx_n == 4'h1));
  // complete while nothing queued or on the line
  assign tc = ~en | (s.tx_empty & (s.tx_st == TX_IDLE) & ~s.pre_pend & ~send_break);

  // parity insertion on the outgoing word
  always_comb
  begin
    tx_dat = s.txbuf;
    // parity replaces the top character bit
    if (s.c1[C1_PEN] & m_long)
      tx_dat[8] = (^s.txbuf[7:0]) ^ s.c1[C1_PTY];
    else if (s.c1[C1_PEN])
      tx_dat[7] = (^s.txbuf[6:0]) ^ s.c1[C1_PTY];
  end

  // frame is start, data, stop, sent lsb first
  assign tx_frame = m_long ? {1'b1, tx_dat, 1'b0} : {2'b11, tx_dat[7:0], 1'b0};
  // received data sits high in the shifter before the stop bit
  assign rx_word  = m_long ? s.rx_sh[9:1] : {1'b0, s.rx_sh[9:2]};
  assign rx_msb   = m_long ? rx_word[8] : rx_word[7];
  assign rx_perr  = s.c1[C1_PEN] & ((^rx_word) ^ s.c1[C1_PTY]);

  // ******************************
  // next state
  // ******************************
  always_comb
  begin
    next_s = s;
    next_s.ack = acc;
    next_s.te_q = te;

    // bus access: read data and register writes
    if (acc & ~wb_we_i)
    begin
      case (wb_adr_i)
        SCU_CTRL1: next_s.dat = {1'b0, s.c1};
        SCU_CTRL2: next_s.dat = {1'b0, s.c2};
        SCU_STAT:  next_s.dat = {1'b0, s.tx_empty, tc, s.rx_full, s.idle, 3'b000, s.perr};
        SCU_DATA:  next_s.dat = s.rx_data;
        SCU_BRKC:  next_s.dat = {8'h00, s.break_flag_clear_enable};
        default:   next_s.dat = 9'h000;
      endcase
      // first step of the clear is armed here
      if ((wb_adr_i == SCU_STAT) & ~prot)
      begin
        next_s.arm_te = s.tx_empty;
        next_s.arm_rf = s.rx_full;
        next_s.arm_id = s.idle;
        next_s.arm_pe = s.perr;
      end
      // second step clears, also in an unprotected break
      if ((wb_adr_i == SCU_DATA) & ~prot)
      begin
        if (s.arm_rf)
          next_s.rx_full = 1'b0;
        if (s.arm_id)
          next_s.idle = 1'b0;
        if (s.arm_pe)
          next_s.perr = 1'b0;
        next_s.arm_rf = 1'b0;
        next_s.arm_id = 1'b0;
        next_s.arm_pe = 1'b0;
      end
    end
    else if (acc & wb_we_i)
    begin
      if (wb_sel_i[0])
      begin
        case (wb_adr_i)
          SCU_CTRL1: next_s.c1 = wb_dat_i[7:0];
          SCU_CTRL2:
          begin
            next_s.c2 = wb_dat_i[7:0];
            // enables held while module is off
            if (~en)
            begin
              next_s.c2[C2_TE] = te;
              next_s.c2[C2_RE] = s.c2[C2_RE];
            end
          end
          SCU_BRKC:  next_s.break_flag_clear_enable = wb_dat_i[0];
          SCU_DATA:  next_s.txbuf[7:0] = wb_dat_i[7:0];
          default:   next_s.break_flag_clear_enable = s.break_flag_clear_enable;
        endcase
      end
      if (wb_sel_i[1] & (wb_adr_i == SCU_DATA))
        next_s.txbuf[8] = wb_dat_i[8];
      // a protected write leaves the empty flag alone
      if ((wb_adr_i == SCU_DATA) & wb_sel_i[0] & ~prot)
      begin
        if (s.arm_te)
          next_s.tx_empty = 1'b0;
        next_s.arm_te = 1'b0;
      end
    end

    // input synchroniser, level taken once two stages agree
    next_s.rx_s = {s.rx_s[1:0], shared_receive_pin_i};
    if (s.rx_s[1] == s.rx_s[2])
      next_s.rx_lvl = s.rx_s[2];

    // transmitter engine, runs after the bus so its sets win
    if (~en)
    begin
      // disabled module reports empty and complete
      next_s.tx_st = TX_IDLE;
      next_s.txd = 1'b1;
      next_s.tx_cnt = 16'h0000;
      next_s.pre_pend = 1'b0;
      next_s.brk_tail = 1'b0;
      next_s.tx_empty = 1'b1;
      next_s.te_q = 1'b0;
    end
    else
    begin
      if (s.tx_st != TX_IDLE)
        next_s.tx_cnt = tx_tick ? BIT_CYC - 16'h0001 : s.tx_cnt - 16'h0001;
      // a rising enable queues a preamble
      // clear then set queues one idle character
      if (te & ~s.te_q)
        next_s.pre_pend = 1'b1;
      // a finished break is owed a trailing one
      if ((s.tx_st == TX_BRK) & tx_free)
        next_s.brk_tail = 1'b1;
      if (tx_free)
      begin
        next_s.tx_st = TX_IDLE;
        next_s.txd = 1'b1;
        if (te)
        begin
          if (send_break)
          begin
            // break takes the place of a waiting preamble
            next_s.pre_pend = 1'b0;
            next_s.tx_st = TX_BRK;
            next_s.txd = 1'b0;
            next_s.tx_sh = 10'h000;
            next_s.tx_n = len;
            next_s.tx_cnt = BIT_CYC - 16'h0001;
          end
          else if (next_s.brk_tail)
          begin
            next_s.brk_tail = 1'b0;
            next_s.tx_st = TX_SEND;
            next_s.tx_n = 4'h1;
            next_s.tx_cnt = BIT_CYC - 16'h0001;
          end
          else if (next_s.pre_pend)
          begin
            next_s.pre_pend = 1'b0;
            next_s.tx_st = TX_SEND;
            next_s.tx_sh = 10'h3FF;
            next_s.tx_n = len;
            next_s.tx_cnt = BIT_CYC - 16'h0001;
          end
          else if (~s.tx_empty)
          begin
            // buffer moves to the shifter, empty flag sets
            next_s.tx_empty = 1'b1;
            next_s.tx_st = TX_SEND;
            next_s.txd = tx_frame[0];
            next_s.tx_sh = tx_frame[10:1];
            next_s.tx_n = len;
            next_s.tx_cnt = BIT_CYC - 16'h0001;
          end
        end
      end
      else if (tx_tick)
      begin
        next_s.txd = s.tx_sh[0];
        next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
        next_s.tx_n = s.tx_n - 4'h1;
      end
    end

    // receiver engine
    // disabled receiver stops, flags untouched
    if (~en | ~s.c2[C2_RE])
    begin
      next_s.rx_busy = 1'b0;
      next_s.rx_cnt = 16'h0000;
      next_s.ocnt = 4'h0;
      next_s.idl_done = 1'b0;
    end
    else
    begin
      next_s.rx_cnt = rx_tick ? BIT_CYC - 16'h0001 : s.rx_cnt - 16'h0001;
      // ones counted once per bit time, zero restarts
      if (rx_tick)
        next_s.ocnt = rxin ? ((s.ocnt == 4'hF) ? s.ocnt : s.ocnt + 4'h1) : 4'h0;
      if (~s.rx_busy)
      begin
        if (~rxin)
        begin
          // falling edge: centre on the start bit
          next_s.rx_busy = 1'b1;
          next_s.rx_cnt = half_cyc;
          next_s.rx_n = 4'h0;
          next_s.ocnt = 4'h0;
        end
      end
      else if (rx_tick)
      begin
        next_s.rx_n = s.rx_n + 4'h1;
        if (s.rx_n == 4'h0)
        begin
          // glitch rather than start bit
          if (rxin)
            next_s.rx_busy = 1'b0;
        end
        else if (s.rx_n == len - 4'h1)
        begin
          next_s.rx_busy = 1'b0;
          // with the type bit set, count only after stop
          if (s.c1[C1_IDLE_COUNT_START_SELECT])
            next_s.ocnt = 4'h0;
          if (~receiver_standby | (s.c1[C1_WAKE] & rx_msb))
          begin
            next_s.c2[C2_RWU] = 1'b0;
            next_s.rx_data = rx_word;
            next_s.rx_full = 1'b1;
            next_s.seen = 1'b1;
            // checked with the same parity type
            if (rx_perr)
              next_s.perr = 1'b1;
          end
        end
        else
          next_s.rx_sh = {rxin, s.rx_sh[9:1]};
      end
      // idle line, once per stretch of ones
      if ((s.ocnt >= len) & ~s.idl_done)
      begin
        next_s.idl_done = 1'b1;
        // idle wakeup clears standby, sets no flag
        if (receiver_standby & ~s.c1[C1_WAKE])
          next_s.c2[C2_RWU] = 1'b0;
        else if (s.seen)
        begin
          next_s.idle = 1'b1;
          next_s.seen = 1'b0;
        end
      end
      if (next_s.ocnt == 4'h0)
        next_s.idl_done = 1'b0;
    end
  end

  // ******************************
  // registers
  // ******************************
  // one register stage for the whole block, frozen by ce
  always_ff @(posedge mclk_i)
  begin
    if (~nrst_i)
    begin
      s <= '0;
      s.c1 <= SCU_CTRL_RST;
      s.c2 <= SCU_CTRL_RST;
      s.break_flag_clear_enable <= SCU_BREAK_FLAG_CLEAR_ENABLE_RST;
      s.tx_empty <= 1'b1;
      s.txd <= 1'b1;
      s.tx_st <= TX_IDLE;
      s.rx_s <= 3'b111;
      s.rx_lvl <= 1'b1;
    end
    else if (ce_i)
      s <= next_s;
  end

  // ******************************
  // outputs
  // ******************************
  assign wb_ack_o = s.ack;
  assign wb_dat_o = {23'h000000, s.dat};

  // enabled module owns both pin directions
  assign shared_transmit_pin_oe_o = en | port_dir_bit_two_i;
  assign shared_receive_pin_oe_o  = ~en & port_dir_bit_one_i;
  assign shared_receive_pin_o     = port_rx_dat_i;
  // inversion covers idle, break, start and stop
  assign shared_transmit_pin_o    = en ? (s.txd ^ s.c1[C1_INV]) : port_tx_dat_i;

  // transmitter sources, killed by module disable
  // gated or of flags, held while true
  assign tx_irq_o = en & ((s.tx_empty & s.c2[C2_TIE]) | (tc & s.c2[C2_TX_COMPLETE_IRQ_ENABLE]));
  assign rx_irq_o = ~receiver_standby & ((s.rx_full & s.c2[C2_RIE]) | (s.idle & s.c2[C2_IDLE_LINE_IRQ_ENABLE]));

endmodule // scu_sci_ctrl
`default_nettype wire

// >>> bench/scu_sci_ctrl_checker.sv
// port checker for the serial control block
// assumes it is bound onto scu_sci_ctrl, one clock
`timescale 1ns/100ps
`default_nettype none
module scu_sci_ctrl_checker
  import scu_pkg::*;
#(
  parameter logic [15:0] BIT_CYC = scu_pkg::SCU_BIT_CYC
)(
  input wire logic        mclk_i,                   // clock
  input wire logic        nrst_i,                   // reset, low
  input wire logic        wb_cyc_i,                 // cycle
  input wire logic        wb_stb_i,                 // strobe
  input wire logic        wb_we_i,                  // write
  input wire logic [7:0]  wb_adr_i,                 // address
  input wire logic [31:0] wb_dat_i,                 // write data
  input wire logic        wb_ack_o,                 // ack
  input wire logic        port_dir_bit_one_i,       // rx dir
  input wire logic        port_dir_bit_two_i,       // tx dir
  input wire logic        port_tx_dat_i,            // tx latch
  input wire logic        shared_transmit_pin_o,    // tx level
  input wire logic        shared_transmit_pin_oe_o, // tx drive
  input wire logic        shared_receive_pin_oe_o,  // rx drive
  input wire logic        tx_irq_o,                 // tx request
  input wire logic        rx_irq_o                  // rx request
);
  // ********
  // control shadow
  // ********
  logic [7:0]  c1_q, c2_q, c1, c2;
  logic [15:0] quiet;
  logic        wr;
  // the write being acked already shows in the design
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign c1 = (wr && wb_adr_i == SCU_CTRL1) ? wb_dat_i[7:0] : c1_q;
  // enables of both directions stick while the module is off
  assign c2 = !(wr && wb_adr_i == SCU_CTRL2) ? c2_q :
              c1_q[C1_EN] ? wb_dat_i[7:0] : {wb_dat_i[7:4], c2_q[3:2], wb_dat_i[1:0]};
  // quiet counts cycles since the last write other than to SCU_BRKC, saturating
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      c1_q  <= 8'h00;
      c2_q  <= 8'h00;
      quiet <= 16'h0000;
    end
    else
    begin
      c1_q  <= c1;
      c2_q  <= c2;
      quiet <= (wr && wb_adr_i != SCU_BRKC) ? 16'h0000 : quiet + {15'h0000, quiet != 16'hFFFF};
    end
  end
  // ********
  // properties
  // ********
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_tx_pin_out: assert property (c1[C1_EN] |-> shared_transmit_pin_oe_o)
    else $error("tx pin not driven while enabled");
  chk_rx_pin_in: assert property (c1[C1_EN] |-> !shared_receive_pin_oe_o)
    else $error("rx pin driven while enabled");
  chk_port_owns_pins: assert property (!c1[C1_EN] |-> shared_transmit_pin_oe_o == port_dir_bit_two_i
    && shared_receive_pin_oe_o == port_dir_bit_one_i)
    else $error("pin drive not from port bits");
  chk_off_port_level: assert property (!c1[C1_EN] |-> shared_transmit_pin_o == port_tx_dat_i)
    else $error("tx pin not from port latch");
  chk_off_no_txirq: assert property (!c1[C1_EN] |-> !tx_irq_o)
    else $error("tx request while module off");
  chk_txirq_masked: assert property (!c2[C2_TIE] && !c2[C2_TX_COMPLETE_IRQ_ENABLE] |-> !tx_irq_o)
    else $error("tx request with sources masked");
  chk_rxirq_masked: assert property (!c2[C2_RIE] && !c2[C2_IDLE_LINE_IRQ_ENABLE] |-> !rx_irq_o)
    else $error("rx request with sources masked");
  chk_idle_level: assert property (c1[C1_EN] && !c1[C1_LOOP] && !c2[C2_TE] && !c2[C2_SBK]
    && int'(quiet) > 12 * int'(BIT_CYC) |-> shared_transmit_pin_o != c1[C1_INV])
    else $error("idle level wrong");
  cov_break: cover property (c2[C2_SBK] && c1[C1_EN]);
  cov_loop: cover property (c1[C1_LOOP] && c2[C2_TE]);
  cov_txirq: cover property (tx_irq_o);
  cov_rxirq: cover property (rx_irq_o);
endmodule // scu_sci_ctrl_checker
`default_nettype wire

// >>> bench/scu_far_end.sv
// far-end serial model: character source and frame catcher
// assumes lsb first frames timed on the bench clock
`timescale 1ns/100ps
`default_nettype none
module scu_far_end #(
  parameter int BC = 4
)(
  input  wire logic       mclk_i,  // bench clock
  input  wire logic       line_i,  // tx pin of the block
  input  wire logic       inv_i,   // expected inversion
  output var  logic       rxd_o,   // into the rx pin
  output var  logic [9:0] frame_o, // bits after a start
  output var  int         nfr_o    // frames caught
);
  // ********
  // source
  // ********
  initial rxd_o = 1'b1;
  // start bit, lsb first, then idle one
  task automatic send(input logic [9:0] bits);
    rxd_o <= 1'b0;
    repeat (BC) @(posedge mclk_i);
    for (int i = 0; i < 10; i++)
    begin
      rxd_o <= bits[i];
      repeat (BC) @(posedge mclk_i);
    end
    rxd_o <= 1'b1;
  endtask
  // ********
  // catcher
  // ********
  // start must still be low at mid-bit, so level flips are dropped
  initial
  begin
    nfr_o = 0;
    frame_o = 10'h000;
    forever
    begin
      @(posedge mclk_i);
      if ((line_i ^ inv_i) === 1'b0)
      begin
        repeat (BC / 2) @(posedge mclk_i);
        if ((line_i ^ inv_i) === 1'b0)
        begin
          for (int i = 0; i < 10; i++)
          begin
            repeat (BC) @(posedge mclk_i);
            frame_o[i] = line_i ^ inv_i;
          end
          nfr_o = nfr_o + 1;
        end
      end
    end
  end
endmodule // scu_far_end
`default_nettype wire

// >>> bench/scu_sci_ctrl_test.sv
// bench for the serial control block: registers, frames, flags
// assumes the far-end model and the checker files
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module scu_sci_ctrl_test;
  import scu_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} scu_row_t;
  typedef struct packed {logic [7:0] c; logic [8:0] d; logic [9:0] f;} scu_fmt_t;
  localparam int BC = 4;
  logic        mclk_i = 1'b0, nrst_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        dbg = 1'b0, pd1 = 1'b0, pd2 = 1'b0, ptx = 1'b1, jam = 1'b0, inv = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, q;
  logic        ack, txp, txirq, rxirq, far_rxd, rxo;
  logic [9:0]  frame;
  int          nfr, lows, n_mismatch = 0, samples_checked = 0;
  scu_row_t    rows [12];
  scu_fmt_t    fmts [7];
  // ********
  // clock, design, far end
  // ********
  always #50 mclk_i = ~mclk_i;
  scu_sci_ctrl #(.BIT_CYC(16'(BC))) dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .dbg_break_i(dbg), .port_dir_bit_one_i(pd1),
    .port_dir_bit_two_i(pd2), .port_tx_dat_i(ptx), .port_rx_dat_i(~ptx), .shared_transmit_pin_o(txp),
    .shared_transmit_pin_oe_o(), .shared_receive_pin_i(jam ? 1'b0 : far_rxd), .shared_receive_pin_o(rxo),
    .shared_receive_pin_oe_o(), .tx_irq_o(txirq), .rx_irq_o(rxirq));
  scu_far_end #(.BC(BC)) far_u (.mclk_i(mclk_i), .line_i(txp), .inv_i(inv), .rxd_o(far_rxd),
    .frame_o(frame), .nfr_o(nfr));
  // ********
  // tasks
  // ********
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    @(posedge mclk_i);
    while (ack !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge mclk_i);
    end
    if (n >= 50) begin n_mismatch++; end_sim(); end
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic wait_frame();
    int n0, n;
    n0 = nfr;
    n = 0;
    while (nfr == n0 && n < 2000) begin n++; @(posedge mclk_i); end
    if (n >= 2000) begin n_mismatch++; end_sim(); end
  endtask
  // polling status also arms the flags for clearing
  task automatic wait_rx();
    int n;
    n = 0;
    do begin wb(0, SCU_STAT, 0); n++; end while (q[5] !== 1'b1 && n < 200);
    if (n >= 200) begin n_mismatch++; end_sim(); end
  endtask
  // ********
  // sequence
  // ********
  initial begin repeat (100000) @(posedge mclk_i); n_mismatch++; end_sim(); end
  initial
  begin
    // row five writes both enables while off, and must be refused
    rows = '{'{0, SCU_CTRL1, 8'h00}, '{0, SCU_CTRL2, 8'h00}, '{0, SCU_STAT, 8'hC0}, '{0, SCU_BRKC, 8'h00},
             '{1, SCU_CTRL2, 8'h0C}, '{0, SCU_CTRL2, 8'h00}, '{1, 8'h14, 8'h55}, '{0, 8'h14, 8'h00},
             '{1, SCU_CTRL1, 8'h40}, '{0, SCU_CTRL1, 8'h40}, '{1, SCU_CTRL2, 8'hF0}, '{0, SCU_CTRL2, 8'hF0}};
    fmts = '{'{8'h40, 9'h05A, 10'h35A}, '{8'h42, 9'h007, 10'h387}, '{8'h43, 9'h007, 10'h307},
             '{8'h52, 9'h007, 10'h307}, '{8'h53, 9'h007, 10'h207}, '{8'h50, 9'h0A5, 10'h2A5},
             '{8'h60, 9'h0A5, 10'h3A5}};
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    foreach (rows[i])
    begin
      wb(rows[i].w, rows[i].a, {24'h0, rows[i].d});
      if (!rows[i].w) `CHK("reg", rows[i].d, q[7:0])
    end
    `CHK("tx_irq", 1'b1, txirq)
    `CHK("rx_irq", 1'b0, rxirq)
    $display("test registers done");
    pd1 <= 1'b1; pd2 <= 1'b1;
    wb(1, SCU_CTRL2, 32'h0C);
    wb(0, SCU_STAT, 0);
    `CHK("preamble_busy", 1'b0, q[6])
    lows = 0;
    repeat (10 * BC) begin @(posedge mclk_i); if (txp !== 1'b1) lows++; end
    `CHK("preamble", 0, lows)
    foreach (fmts[i])
    begin
      wb(1, SCU_CTRL1, {24'h0, fmts[i].c});
      inv <= fmts[i].c[5];
      wb(0, SCU_STAT, 0);
      wb(1, SCU_DATA, {23'h0, fmts[i].d});
      wait_frame();
      `CHK("frame", fmts[i].f, frame)
    end
    $display("test formats done");
    wb(1, SCU_CTRL1, 32'h40);
    inv <= 1'b0;
    wb(1, SCU_CTRL2, 32'h0D);
    repeat (2) begin wait_frame(); `CHK("break", 10'h000, frame) end
    wb(1, SCU_CTRL2, 32'h0C);
    repeat (30 * BC) @(posedge mclk_i);
    `CHK("idle", 1'b1, txp)
    wb(0, SCU_STAT, 0);
    wb(1, SCU_DATA, 32'hC3);
    wb(1, SCU_CTRL2, 32'h04);
    wait_frame();
    `CHK("te_off", 10'h3C3, frame)
    $display("test transmitter done");
    wb(1, SCU_CTRL1, 32'h48);
    wb(1, SCU_CTRL2, 32'h24);
    far_u.send(10'h396);
    wait_rx();
    `CHK("rx_irq", 1'b1, rxirq)
    repeat (12 * BC) @(posedge mclk_i);
    wb(0, SCU_STAT, 0);
    `CHK("rx_idle", 1'b1, q[4])
    wb(1, SCU_CTRL2, 32'h26);
    `CHK("standby", 1'b0, rxirq)
    far_u.send(10'h396);
    wb(0, SCU_CTRL2, 0);
    `CHK("woken", 8'h24, q[7:0])
    wb(1, SCU_CTRL2, 32'h20);
    wb(0, SCU_STAT, 0);
    `CHK("rx_full", 1'b1, q[5])
    dbg <= 1'b1;
    wb(0, SCU_DATA, 0);
    `CHK("rx_data", 8'h96, q[7:0])
    wb(0, SCU_STAT, 0);
    `CHK("frozen", 1'b1, q[5])
    dbg <= 1'b0;
    wb(0, SCU_DATA, 0);
    wb(0, SCU_STAT, 0);
    `CHK("cleared", 1'b0, q[5])
    wb(1, SCU_BRKC, 32'h1);
    wb(1, SCU_CTRL2, 32'h24);
    far_u.send(10'h33C);
    wait_rx();
    dbg <= 1'b1;
    wb(0, SCU_STAT, 0);
    wb(0, SCU_DATA, 0);
    dbg <= 1'b0;
    wb(0, SCU_STAT, 0);
    `CHK("break_clear", 1'b0, q[5])
    $display("test receiver done");
    jam <= 1'b1;
    wb(1, SCU_CTRL1, 32'hC0);
    // both directions on before loop traffic
    wb(1, SCU_CTRL2, 32'h0C);
    wb(0, SCU_STAT, 0);
    wb(1, SCU_DATA, 32'h5A);
    wait_rx();
    wb(0, SCU_DATA, 0);
    `CHK("loop", 8'h5A, q[7:0])
    wb(0, SCU_STAT, 0);
    wb(1, SCU_DATA, 32'hFF);
    wb(1, SCU_CTRL2, 32'h8C);
    ptx <= 1'b0; pd2 <= 1'b0;
    wb(1, SCU_CTRL1, 32'h00);
    wb(0, SCU_STAT, 0);
    `CHK("off_flags", 2'b11, q[7:6])
    `CHK("off_irq", 1'b0, txirq)
    `CHK("rx_pin_out", ~ptx, rxo)
    $display("test loop and disable done");
    nrst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    wb(0, SCU_CTRL2, 0);
    `CHK("reset_ctrl2", 8'h00, q[7:0])
    wb(0, SCU_STAT, 0);
    `CHK("reset_stat", 8'hC0, q[7:0])
    $display("test reset done");
    end_sim();
  end
endmodule // scu_sci_ctrl_test
bind scu_sci_ctrl scu_sci_ctrl_checker #(.BIT_CYC(BIT_CYC)) chk_u (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .port_dir_bit_one_i(port_dir_bit_one_i), .port_dir_bit_two_i(port_dir_bit_two_i),
  .port_tx_dat_i(port_tx_dat_i), .shared_transmit_pin_o(shared_transmit_pin_o),
  .shared_transmit_pin_oe_o(shared_transmit_pin_oe_o), .shared_receive_pin_oe_o(shared_receive_pin_oe_o),
  .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
`default_nettype wire
